// ===== rtl/iamd_unit.sv
// integer add/subtract extended, negate, multiply and divide datapath
// assumes issue logic holds operands only in the issue cycle and waits on busy
`timescale 1ns/1ps
module iamd_unit (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic             issueValid,
	input  wire iamd_pkg::iamd_op_t opCode,
	input  wire logic             recordEn,
	input  wire logic             overflowEn,
	input  wire logic [31:0]      firstSourceGpr,
	input  wire logic [31:0]      secondSourceGpr,
	input  wire logic [15:0]      signedImmediate,
	output logic                  busy_ff,
	output logic                  resValid_ff,
	output logic [31:0]           resData_ff,
	output logic                  condWe_ff,
	output logic [3:0]            conditionFlags_ff,
	output logic                  borrowFlag_ff,
	output logic                  resultWrapFlag_ff,
	output logic                  summaryWrap_ff
);
	typedef enum logic {ST_IDLE, ST_DIV} iamd_state_t;
	iamd_state_t stateFf, nxtState;
	iamd_div_if  divBus ();
	logic        divStart_ff, nxt_divStart, divSigned_ff, nxt_divSigned;
	logic [31:0] divA_ff, nxt_divA, divB_ff, nxt_divB;
	logic        recPend_ff, nxt_recPend, ovfPend_ff, nxt_ovfPend;
	logic        nxt_busy, nxt_resValid, nxt_condWe;
	logic [31:0] nxt_resData;
	logic [3:0]  nxt_conditionFlags;
	logic        nxt_borrowFlag, nxt_resultWrapFlag, nxt_summaryWrap;
	logic        accept;
	logic [31:0] addX, addY, mulB, aluRes;
	logic        addCin, aluWrap, writesCarry, recOk, wrapOk, isDiv;
	logic [32:0] addSum;
	logic signed [63:0] prodS;
	logic [63:0] prodU;
	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [3:0] condOf(input logic [31:0] r, input logic so);
		condOf = 4'h0;
		condOf[iamd_pkg::COND_LT] = r[31];
		condOf[iamd_pkg::COND_GT] = !r[31] && (r != iamd_pkg::ZERO_WORD);
		condOf[iamd_pkg::COND_EQ] = (r == iamd_pkg::ZERO_WORD);
		condOf[iamd_pkg::COND_SO] = so;
	endfunction : condOf
	// ------------------------------------------------------------------
	// arithmetic
	// ------------------------------------------------------------------
	always_comb begin
		addX = firstSourceGpr;
		addY = iamd_pkg::ZERO_WORD;
		addCin = borrowFlag_ff;
		writesCarry = 1'b1;
		recOk = 1'b1;
		wrapOk = 1'b1;
		isDiv = 1'b0;
		mulB = secondSourceGpr;
		case (opCode)
			iamd_pkg::OP_ADD_EXT: begin
				addY = secondSourceGpr;
			end
			iamd_pkg::OP_SUB_EXT: begin
				addX = ~firstSourceGpr;
				addY = secondSourceGpr;
			end
			iamd_pkg::OP_ADD_MINUS1: begin
				addY = iamd_pkg::MINUS_ONE;
			end
			iamd_pkg::OP_SUB_MINUS1: begin
				addX = ~firstSourceGpr;
				addY = iamd_pkg::MINUS_ONE;
			end
			iamd_pkg::OP_ADD_ZERO: begin
				addY = iamd_pkg::ZERO_WORD;
			end
			iamd_pkg::OP_SUB_ZERO: begin
				addX = ~firstSourceGpr;
			end
			iamd_pkg::OP_NEGATE: begin
				addX = ~firstSourceGpr;
				addCin = 1'b1;
				writesCarry = 1'b0;
			end
			iamd_pkg::OP_MUL_LOW_IMM: begin
				mulB = {{16{signedImmediate[15]}}, signedImmediate};
				writesCarry = 1'b0;
				recOk = 1'b0;
				wrapOk = 1'b0;
			end
			iamd_pkg::OP_MUL_LOW: begin
				writesCarry = 1'b0;
			end
			iamd_pkg::OP_MUL_HIGH_S, iamd_pkg::OP_MUL_HIGH_U: begin
				writesCarry = 1'b0;
				wrapOk = 1'b0;
			end
			iamd_pkg::OP_DIV_S, iamd_pkg::OP_DIV_U: begin
				writesCarry = 1'b0;
				isDiv = 1'b1;
			end
			default: begin
				writesCarry = 1'b0;
				recOk = 1'b0;
				wrapOk = 1'b0;
			end
		endcase
		addSum = {1'b0, addX} + {1'b0, addY} + {32'h0000_0000, addCin};
		prodS = 64'($signed(firstSourceGpr)) * 64'($signed(mulB));
		prodU = {32'h0000_0000, firstSourceGpr} * {32'h0000_0000, secondSourceGpr};
		case (opCode)
			iamd_pkg::OP_MUL_LOW_IMM, iamd_pkg::OP_MUL_LOW: begin
				aluRes = prodS[31:0];
				aluWrap = (prodS[63:31] != {33{prodS[31]}});
			end
			iamd_pkg::OP_MUL_HIGH_S: begin
				aluRes = prodS[63:32];
				aluWrap = 1'b0;
			end
			iamd_pkg::OP_MUL_HIGH_U: begin
				aluRes = prodU[63:32];
				aluWrap = 1'b0;
			end
			default: begin
				aluRes = addSum[31:0];
				aluWrap = (addX[31] == addY[31]) && (addSum[31] != addX[31]);
			end
		endcase
	end
	// ------------------------------------------------------------------
	// issue, writeback and flags
	// ------------------------------------------------------------------
	always_comb begin
		accept = issueValid && (stateFf == ST_IDLE);
		nxtState = stateFf;
		nxt_divStart = 1'b0;
		nxt_divSigned = divSigned_ff;
		nxt_divA = divA_ff;
		nxt_divB = divB_ff;
		nxt_recPend = recPend_ff;
		nxt_ovfPend = ovfPend_ff;
		nxt_resValid = 1'b0;
		nxt_resData = resData_ff;
		nxt_condWe = 1'b0;
		nxt_conditionFlags = conditionFlags_ff;
		nxt_borrowFlag = borrowFlag_ff;
		nxt_resultWrapFlag = resultWrapFlag_ff;
		nxt_summaryWrap = summaryWrap_ff;
		case (stateFf)
			ST_IDLE: begin
				if (accept && isDiv) begin
					nxt_divStart = 1'b1;
					nxt_divSigned = (opCode == iamd_pkg::OP_DIV_S);
					nxt_divA = firstSourceGpr;
					nxt_divB = secondSourceGpr;
					nxt_recPend = recordEn;
					nxt_ovfPend = overflowEn;
					nxtState = ST_DIV;
				end else if (accept) begin
					nxt_resValid = 1'b1;
					nxt_resData = aluRes;
					if (writesCarry) begin
						nxt_borrowFlag = addSum[32];
					end
					if (overflowEn && wrapOk) begin
						nxt_resultWrapFlag = aluWrap;
						nxt_summaryWrap = summaryWrap_ff || aluWrap;
					end
					if (recordEn && recOk) begin
						nxt_condWe = 1'b1;
						nxt_conditionFlags = condOf(aluRes, nxt_summaryWrap);
					end
				end
			end
			ST_DIV: begin
				if (divBus.done) begin
					nxt_resValid = 1'b1;
					nxt_resData = divBus.quotient;
					if (ovfPend_ff) begin
						nxt_resultWrapFlag = divBus.overflow;
						nxt_summaryWrap = summaryWrap_ff || divBus.overflow;
					end
					if (recPend_ff) begin
						nxt_condWe = 1'b1;
						nxt_conditionFlags = condOf(divBus.quotient, nxt_summaryWrap);
					end
					nxtState = ST_IDLE;
				end
			end
			default: nxtState = ST_IDLE;
		endcase
		nxt_busy = (nxtState != ST_IDLE);
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stateFf           <= ST_IDLE;
			busy_ff           <= 1'b0;
			divStart_ff       <= 1'b0;
			divSigned_ff      <= 1'b0;
			divA_ff           <= iamd_pkg::DATA_RESET;
			divB_ff           <= iamd_pkg::DATA_RESET;
			recPend_ff        <= 1'b0;
			ovfPend_ff        <= 1'b0;
			resValid_ff       <= 1'b0;
			resData_ff        <= iamd_pkg::DATA_RESET;
			condWe_ff         <= 1'b0;
			conditionFlags_ff <= iamd_pkg::COND_RESET;
			borrowFlag_ff     <= iamd_pkg::FLAG_RESET;
			resultWrapFlag_ff <= iamd_pkg::FLAG_RESET;
			summaryWrap_ff    <= iamd_pkg::FLAG_RESET;
		end else begin
			stateFf           <= nxtState;
			busy_ff           <= nxt_busy;
			divStart_ff       <= nxt_divStart;
			divSigned_ff      <= nxt_divSigned;
			divA_ff           <= nxt_divA;
			divB_ff           <= nxt_divB;
			recPend_ff        <= nxt_recPend;
			ovfPend_ff        <= nxt_ovfPend;
			resValid_ff       <= nxt_resValid;
			resData_ff        <= nxt_resData;
			condWe_ff         <= nxt_condWe;
			conditionFlags_ff <= nxt_conditionFlags;
			borrowFlag_ff     <= nxt_borrowFlag;
			resultWrapFlag_ff <= nxt_resultWrapFlag;
			summaryWrap_ff    <= nxt_summaryWrap;
		end
	end
	assign divBus.start     = divStart_ff;
	assign divBus.signedDiv = divSigned_ff;
	assign divBus.dividend  = divA_ff;
	assign divBus.divisor   = divB_ff;
	iamd_divider uDiv (
		.clk    (clk),
		.arst_n (arst_n),
		.dv     (divBus.divider)
	);
	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence sIssue(iamd_pkg::iamd_op_t op);
		issueValid && !busy_ff && opCode == op;
	endsequence
	chk_sub_minus1: assert property (sIssue(iamd_pkg::OP_SUB_MINUS1) |=>
		resData_ff == 32'(~$past(firstSourceGpr) + iamd_pkg::MINUS_ONE
		+ {31'h0000_0000, $past(borrowFlag_ff)}))
		else $error("minus-one subtract result wrong");
	chk_add_zero: assert property (sIssue(iamd_pkg::OP_ADD_ZERO) |=>
		resValid_ff && resData_ff == 32'($past(firstSourceGpr)
		+ {31'h0000_0000, $past(borrowFlag_ff)}))
		else $error("zero add result wrong");
	chk_sub_zero: assert property (sIssue(iamd_pkg::OP_SUB_ZERO) |=>
		resData_ff == 32'(~$past(firstSourceGpr) + {31'h0000_0000, $past(borrowFlag_ff)}))
		else $error("zero subtract result wrong");
	chk_negate_val: assert property (sIssue(iamd_pkg::OP_NEGATE) |=>
		resData_ff == 32'(-$past(firstSourceGpr)) && borrowFlag_ff == $past(borrowFlag_ff))
		else $error("negate result wrong");
	chk_mul_high_u: assert property (sIssue(iamd_pkg::OP_MUL_HIGH_U) |=>
		resData_ff == 32'(({32'h0000_0000, $past(firstSourceGpr)}
		* {32'h0000_0000, $past(secondSourceGpr)}) >> 32))
		else $error("unsigned high product wrong");
	chk_sub_ext: assert property (sIssue(iamd_pkg::OP_SUB_EXT) |=>
		{borrowFlag_ff, resData_ff} == ({1'b0, ~$past(firstSourceGpr)}
		+ {1'b0, $past(secondSourceGpr)} + {32'h0000_0000, $past(borrowFlag_ff)}))
		else $error("reverse subtract or carry wrong");
	chk_plain_cond: assert property ((issueValid && !busy_ff && !recordEn) |=>
		!condWe_ff)
		else $error("plain form wrote condition field");
	chk_plain_div: assert property ((divBus.done && !recPend_ff) |=>
		(resValid_ff && !condWe_ff))
		else $error("plain divide wrote condition field");
	chk_wrap_hold: assert property ((issueValid && !busy_ff && !overflowEn) |=>
		$stable(resultWrapFlag_ff))
		else $error("wrap flag touched without overflow form");
	chk_cond_value: assert property (condWe_ff |->
		conditionFlags_ff[iamd_pkg::COND_EQ] == (resData_ff == iamd_pkg::ZERO_WORD)
		&& conditionFlags_ff[iamd_pkg::COND_SO] == summaryWrap_ff)
		else $error("condition field disagrees with result");
	chk_div_both: assert property ((issueValid && !busy_ff && recordEn && overflowEn
		&& opCode == iamd_pkg::OP_DIV_U && secondSourceGpr == iamd_pkg::ZERO_WORD)
		|-> ##[2:4] (resValid_ff && condWe_ff
		&& resultWrapFlag_ff && summaryWrap_ff))
		else $error("divide by zero not reported in both places");
endmodule : iamd_unit

// ===== include/iamd_pkg.sv
// constants and types of the integer arithmetic, multiply and divide unit
// assumes one core clock and one asynchronous active-low reset
package iamd_pkg;
	// ------------------------------------------------------------------
	// widths and constants
	// ------------------------------------------------------------------
	localparam int          XLEN      = 32;
	localparam int          IMM_W     = 16;
	localparam int          COND_W    = 4;
	localparam logic [31:0] MINUS_ONE = 32'hFFFF_FFFF;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [31:0] MOST_NEG  = 32'h8000_0000;
	localparam logic [5:0]  DIV_STEPS = 6'h20;
	// ------------------------------------------------------------------
	// condition field layout and reset values
	// ------------------------------------------------------------------
	localparam int          COND_LT    = 3;
	localparam int          COND_GT    = 2;
	localparam int          COND_EQ    = 1;
	localparam int          COND_SO    = 0;
	localparam logic [3:0]  COND_RESET = 4'h0;
	localparam logic        FLAG_RESET = 1'b0;
	localparam logic [31:0] DATA_RESET = 32'h0000_0000;
	// ------------------------------------------------------------------
	// operations
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_ADD_EXT,
		OP_SUB_EXT,
		OP_ADD_MINUS1,
		OP_SUB_MINUS1,
		OP_ADD_ZERO,
		OP_SUB_ZERO,
		OP_NEGATE,
		OP_MUL_LOW_IMM,
		OP_MUL_LOW,
		OP_MUL_HIGH_S,
		OP_MUL_HIGH_U,
		OP_DIV_S,
		OP_DIV_U
	} iamd_op_t;
endpackage : iamd_pkg

// ===== include/iamd_div_if.sv
// carrier between the unit's control and its iterative divider
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface iamd_div_if;
	logic        start;
	logic        signedDiv;
	logic [31:0] dividend;
	logic [31:0] divisor;
	logic        done;
	logic [31:0] quotient;
	logic        overflow;
	modport ctrl (output start, output signedDiv, output dividend, output divisor,
		input done, input quotient, input overflow);
	modport divider (input start, input signedDiv, input dividend, input divisor,
		output done, output quotient, output overflow);
endinterface : iamd_div_if

// ===== rtl/iamd_divider.sv
// iterative 32-step restoring divider, quotient only
// assumes start is a one-cycle pulse and operands hold only in that cycle
`timescale 1ns/1ps
module iamd_divider (
	input wire logic clk,
	input wire logic arst_n,
	iamd_div_if.divider dv
);
	typedef enum logic {DV_IDLE, DV_RUN} iamd_dv_state_t;
	iamd_dv_state_t stateFf, nxtState;
	logic [32:0] rem_ff, nxt_rem;
	logic [31:0] quo_ff, nxt_quo, dsr_ff, nxt_dsr, res_ff, nxt_res;
	logic [5:0]  cnt_ff, nxt_cnt;
	logic        negQ_ff, nxt_negQ, done_ff, nxt_done, ovf_ff, nxt_ovf;
	logic [32:0] trial;
	logic [31:0] absA, absB;
	logic        divBad;
	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		absA = (dv.signedDiv && dv.dividend[31]) ? 32'(-dv.dividend) : dv.dividend;
		absB = (dv.signedDiv && dv.divisor[31]) ? 32'(-dv.divisor) : dv.divisor;
		divBad = (dv.divisor == iamd_pkg::ZERO_WORD) ||
			(dv.signedDiv && dv.dividend == iamd_pkg::MOST_NEG &&
			dv.divisor == iamd_pkg::MINUS_ONE);
		trial = {rem_ff[31:0], quo_ff[31]} - {1'b0, dsr_ff};
		nxtState = stateFf;
		nxt_rem = rem_ff;
		nxt_quo = quo_ff;
		nxt_dsr = dsr_ff;
		nxt_res = res_ff;
		nxt_cnt = cnt_ff;
		nxt_negQ = negQ_ff;
		nxt_done = 1'b0;
		nxt_ovf = ovf_ff;
		case (stateFf)
			DV_IDLE: begin
				if (dv.start) begin
					nxt_ovf = divBad;
					if (divBad) begin
						nxt_res = iamd_pkg::DATA_RESET;
						nxt_done = 1'b1;
					end else begin
						nxt_rem = 33'h0_0000_0000;
						nxt_quo = absA;
						nxt_dsr = absB;
						nxt_cnt = iamd_pkg::DIV_STEPS;
						nxt_negQ = dv.signedDiv && (dv.dividend[31] ^ dv.divisor[31]);
						nxtState = DV_RUN;
					end
				end
			end
			DV_RUN: begin
				if (!trial[32]) begin
					nxt_rem = trial;
					nxt_quo = {quo_ff[30:0], 1'b1};
				end else begin
					nxt_rem = {rem_ff[31:0], quo_ff[31]};
					nxt_quo = {quo_ff[30:0], 1'b0};
				end
				nxt_cnt = 6'(cnt_ff - 6'h01);
				if (cnt_ff == 6'h01) begin
					nxt_res = negQ_ff ? 32'(-nxt_quo) : nxt_quo;
					nxt_done = 1'b1;
					nxtState = DV_IDLE;
				end
			end
			default: nxtState = DV_IDLE;
		endcase
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stateFf <= DV_IDLE;
			rem_ff  <= 33'h0_0000_0000;
			quo_ff  <= iamd_pkg::DATA_RESET;
			dsr_ff  <= iamd_pkg::DATA_RESET;
			res_ff  <= iamd_pkg::DATA_RESET;
			cnt_ff  <= 6'h00;
			negQ_ff <= 1'b0;
			done_ff <= 1'b0;
			ovf_ff  <= 1'b0;
		end else begin
			stateFf <= nxtState;
			rem_ff  <= nxt_rem;
			quo_ff  <= nxt_quo;
			dsr_ff  <= nxt_dsr;
			res_ff  <= nxt_res;
			cnt_ff  <= nxt_cnt;
			negQ_ff <= nxt_negQ;
			done_ff <= nxt_done;
			ovf_ff  <= nxt_ovf;
		end
	end
	assign dv.done     = done_ff;
	assign dv.quotient = res_ff;
	assign dv.overflow = ovf_ff;
	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	chk_div_zero: assert property (@(posedge clk) disable iff (!arst_n)
		(dv.start && stateFf == DV_IDLE && dv.divisor == iamd_pkg::ZERO_WORD)
		|=> (done_ff && ovf_ff))
		else $error("zero divisor not flagged");
	chk_div_latency: assert property (@(posedge clk) disable iff (!arst_n)
		(dv.start && stateFf == DV_IDLE && !divBad) |=> !done_ff [*8] ##[25:25] done_ff)
		else $error("divide did not finish in 33 cycles");
endmodule : iamd_divider

// ===== testbench/iamd_issue_model.sv
// issue-side model: drives one operation, then waits for its result
// assumes a free-running clk and the unit's busy level and result pulse
`timescale 1ns/1ps
module iamd_issue_model (
	input  wire logic               clk,
	input  wire logic               busy_ff,
	input  wire logic               resValid_ff,
	output logic                    issueValid,
	output iamd_pkg::iamd_op_t      opCode,
	output logic                    recordEn,
	output logic                    overflowEn,
	output logic [31:0]             firstSourceGpr,
	output logic [31:0]             secondSourceGpr,
	output logic [15:0]             signedImmediate
);
	// ------------------------------------------------------------------
	// idle values
	// ------------------------------------------------------------------
	initial begin
		issueValid = 1'b0;
		opCode = iamd_pkg::OP_ADD_EXT;
		recordEn = 1'b0;
		overflowEn = 1'b0;
		firstSourceGpr = 32'h0;
		secondSourceGpr = 32'h0;
		signedImmediate = 16'h0;
	end
	// ------------------------------------------------------------------
	// one operation; called at a falling edge
	// ------------------------------------------------------------------
	task automatic issue(input iamd_pkg::iamd_op_t op, input logic [3:0] mode,
		input logic [31:0] a, input logic [31:0] b, output int lat, output logic bsy);
		lat = 0;
		bsy = 1'b0;
		issueValid = 1'b1;
		opCode = op;
		recordEn = mode[1];
		overflowEn = mode[0];
		firstSourceGpr = a;
		secondSourceGpr = b;
		signedImmediate = b[15:0];
		while (lat < 40) begin
			@(negedge clk);
			lat++;
			if (lat == 1)
				bsy = busy_ff;
			if (resValid_ff === 1'b1)
				break;
			// intruding request while busy
			if (lat == 1 && mode[3] && busy_ff === 1'b1)
				opCode = iamd_pkg::OP_NEGATE;
			else
				issueValid = 1'b0;
		end
	endtask : issue
	task automatic idle;
		issueValid = 1'b0;
	endtask : idle
endmodule : iamd_issue_model

// ===== testbench/integer_arith_mul_div_unit_bench.sv
// self-checking bench of the arithmetic, multiply and divide unit
// assumes the issue model and the unit share one 100 MHz clock
`timescale 1ns/1ps
module integer_arith_mul_div_unit_bench;
	logic               clk;
	logic               arst_n;
	logic               issueValid;
	iamd_pkg::iamd_op_t opCode;
	logic               recordEn;
	logic               overflowEn;
	logic [31:0]        firstSourceGpr;
	logic [31:0]        secondSourceGpr;
	logic [15:0]        signedImmediate;
	logic               busy_ff;
	logic               resValid_ff;
	logic [31:0]        resData_ff;
	logic               condWe_ff;
	logic [3:0]         conditionFlags_ff;
	logic               borrowFlag_ff;
	logic               resultWrapFlag_ff;
	logic               summaryWrap_ff;
	int                 errors;
	int                 compares;
	// ------------------------------------------------------------------
	// instances
	// ------------------------------------------------------------------
	iamd_issue_model m (.clk(clk), .busy_ff(busy_ff), .resValid_ff(resValid_ff),
		.issueValid(issueValid), .opCode(opCode), .recordEn(recordEn),
		.overflowEn(overflowEn), .firstSourceGpr(firstSourceGpr),
		.secondSourceGpr(secondSourceGpr), .signedImmediate(signedImmediate));
	iamd_unit uut (.clk(clk), .arst_n(arst_n), .issueValid(issueValid), .opCode(opCode),
		.recordEn(recordEn), .overflowEn(overflowEn), .firstSourceGpr(firstSourceGpr),
		.secondSourceGpr(secondSourceGpr), .signedImmediate(signedImmediate),
		.busy_ff(busy_ff), .resValid_ff(resValid_ff), .resData_ff(resData_ff),
		.condWe_ff(condWe_ff), .conditionFlags_ff(conditionFlags_ff),
		.borrowFlag_ff(borrowFlag_ff), .resultWrapFlag_ff(resultWrapFlag_ff),
		.summaryWrap_ff(summaryWrap_ff));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test;
		if (errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	// flags: condWe, negative, positive, zero, summary copy, carry, wrap, summary
	task automatic run(input iamd_pkg::iamd_op_t op, input logic [3:0] mode,
		input logic [31:0] a, input logic [31:0] b, input logic [31:0] res,
		input logic [7:0] flags);
		int  lat;
		int  expLat;
		logic isDiv;
		logic bsy;
		isDiv = (op == iamd_pkg::OP_DIV_S) || (op == iamd_pkg::OP_DIV_U);
		expLat = 1;
		if (isDiv)
			expLat = (b == 32'h0 || (op == iamd_pkg::OP_DIV_S && a == 32'h80000000
				&& b == 32'hFFFFFFFF)) ? 3 : 35;
		m.issue(op, mode, a, b, lat, bsy);
		chk(res, resData_ff);
		chk(32'(expLat), 32'(lat));
		chk({30'h0, isDiv, 1'b0}, {30'h0, bsy, busy_ff});
		chk({24'h0, flags}, {24'h0, condWe_ff, conditionFlags_ff, borrowFlag_ff,
			resultWrapFlag_ff, summaryWrap_ff});
	endtask : run
	// ------------------------------------------------------------------
	// tests; mode bits: 3 intrude while busy, 1 record, 0 overflow
	// ------------------------------------------------------------------
	initial begin
		errors = 0;
		compares = 0;
		arst_n = 1'b0;
		repeat (4) @(negedge clk);
		arst_n = 1'b1;
		run(iamd_pkg::OP_ADD_ZERO, 4'h2, 32'hFFFFFFFF, 32'h0, 32'hFFFFFFFF, 8'hC0);
		run(iamd_pkg::OP_ADD_EXT, 4'h2, 32'hFFFFFFFF, 32'h1, 32'h0, 8'h94);
		run(iamd_pkg::OP_ADD_ZERO, 4'h0, 32'h5, 32'h0, 32'h6, 8'h10);
		run(iamd_pkg::OP_SUB_MINUS1, 4'h0, 32'h0, 32'h0, 32'hFFFFFFFE, 8'h14);
		run(iamd_pkg::OP_SUB_ZERO, 4'h0, 32'h5, 32'h0, 32'hFFFFFFFB, 8'h10);
		run(iamd_pkg::OP_SUB_EXT, 4'h2, 32'h3, 32'hA, 32'h6, 8'hA4);
		run(iamd_pkg::OP_ADD_MINUS1, 4'h0, 32'h0, 32'h0, 32'h0, 8'h24);
		run(iamd_pkg::OP_NEGATE, 4'h2, 32'h5, 32'h0, 32'hFFFFFFFB, 8'hC4);
		run(iamd_pkg::OP_MUL_LOW_IMM, 4'h2, 32'h7, 32'hFFFD, 32'hFFFFFFEB, 8'h44);
		run(iamd_pkg::OP_MUL_LOW, 4'h0, 32'h10000, 32'h10003, 32'h30000, 8'h44);
		run(iamd_pkg::OP_MUL_HIGH_S, 4'h3, 32'hFFFFFFFF, 32'h2, 32'hFFFFFFFF, 8'hC4);
		run(iamd_pkg::OP_MUL_HIGH_U, 4'h0, 32'hFFFFFFFF, 32'h2, 32'h1, 8'h44);
		run(iamd_pkg::OP_DIV_S, 4'h8, 32'hFFFFFFF9, 32'h2, 32'hFFFFFFFD, 8'h44);
		run(iamd_pkg::OP_DIV_U, 4'h2, 32'hFFFFFFF9, 32'h2, 32'h7FFFFFFC, 8'hA4);
		run(iamd_pkg::OP_DIV_U, 4'h3, 32'h5, 32'h0, 32'h0, 8'h9F);
		run(iamd_pkg::OP_ADD_ZERO, 4'h0, 32'h1, 32'h0, 32'h2, 8'h1B);
		run(iamd_pkg::OP_NEGATE, 4'h1, 32'h1, 32'h0, 32'hFFFFFFFF, 8'h19);
		run(iamd_pkg::OP_DIV_S, 4'h3, 32'h80000000, 32'hFFFFFFFF, 32'h0, 8'h9B);
		run(iamd_pkg::OP_ADD_EXT, 4'h3, 32'h7FFFFFFF, 32'h1, 32'h80000000, 8'hCB);
		m.idle();
		repeat (2) @(negedge clk);
		end_of_test();
	end
	// ------------------------------------------------------------------
	// watchdog
	// ------------------------------------------------------------------
	initial begin
		repeat (3000) @(posedge clk);
		errors++;
		end_of_test();
	end
endmodule : integer_arith_mul_div_unit_bench
